// >>> bench/pwu_top_bench.sv
// Purpose: Self-checking bench for the periodic wake unit over AHB-Lite.
// Assumes: Every tick input pulses each cycle while enabled; quadrupled ticks always run.
// Notes: Periods are checked inside small windows, since entry latency is the design's.
`timescale 1ns/1ps
`include "pwu_defines.svh"
module pwu_top_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd_q, d;
  logic dbl_on = 0, rc_on = 0, stop_req = 0;
  logic keep, stop_active, cpu_release, wake_irq;
  int mismatches = 0, n_checks = 0, cyc = 0;
  assign hready = hreadyout;
  pwu_top pwu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_clock_doubled(dbl_on),
    .bus_clock_quadrupled(1'b1), .internal_rc_clock(rc_on), .stop_req(stop_req),
    .clock_keep_in_stop(keep), .stop_active(stop_active), .cpu_release(cpu_release),
    .wake_irq(wake_irq));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // Read data is captured at the edge that ends the data phase, before it moves on.
  always @(posedge hclk) begin
    rd_q <= hrdata;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1 d = rd_q;
  endtask : bus
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0);
    chk(d, exp);
  endtask : rdc
  // Counts cycles until the chosen output rises and checks the count lies in [lo, hi).
  task automatic wait_on(input bit rel, input int lo, input int hi);
    int n;
    n = 0;
    while (((rel ? cpu_release : wake_irq) !== 1'b1) && n < hi) begin
      @(posedge hclk);
      #1 n++;
    end
    chk({31'h0, n >= lo && n < hi}, 32'h1);
  endtask : wait_on
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    rdc(`PWU_OFF_OPT_TWO, 32'h0);
    rdc(`PWU_OFF_OPT_ONE, 32'h0); // enable reset
    rdc(`PWU_OFF_STATE, 32'h0);
    rdc(12'h040, 32'h0);
    chk(keep, 1'b1); // idle clock kept
    chk({hreadyout, hresp}, 2'b10); // bus answers okay
    // Short period on the RC clock, short recovery, interrupt unmasked.
    rc_on <= 1;
    bus(1, `PWU_OFF_OPT_ONE, 32'h19);
    bus(1, `PWU_OFF_MASK, 32'h1);
    bus(1, `PWU_OFF_CTRL, 32'h1);
    chk({stop_active, keep}, 2'b10); // osc off in stop
    wait_on(0, 500, 530); // RC short period
    chk({stop_active, keep}, 2'b01); // stop left for recovery
    wait_on(1, 28, 40); // short recovery
    #6 chk(stop_active, 1'b0); // exit stop
    rdc(`PWU_OFF_STATUS, 32'h3); // request latched
    bus(1, `PWU_OFF_STATUS, 32'h3);
    rdc(`PWU_OFF_STATUS, 32'h0);
    chk(wake_irq, 1'b0);
    // Long period on the doubled clock, long recovery, interrupt masked.
    rc_on <= 0;
    dbl_on <= 1;
    bus(1, `PWU_OFF_MASK, 32'h0);
    bus(1, `PWU_OFF_OPT_TWO, 32'h2);
    bus(1, `PWU_OFF_OPT_ONE, 32'h01);
    @(posedge hclk);
    stop_req <= 1;
    @(posedge hclk);
    stop_req <= 0;
    repeat (4) @(posedge hclk);
    #1 chk({stop_active, keep}, 2'b11); // osc kept in stop
    wait_on(1, 20440, 20560); // long period and recovery
    rdc(`PWU_OFF_STATUS, 32'h3);
    chk(wake_irq, 1'b0);
    bus(1, `PWU_OFF_MASK, 32'h1);
    #6 chk(wake_irq, 1'b1);
    bus(1, `PWU_OFF_STATUS, 32'h3);
    #6 chk(wake_irq, 1'b0);
    // With latching disabled the period repeats and stop persists.
    bus(1, `PWU_OFF_OPT_ONE, 32'h10);
    bus(1, `PWU_OFF_CTRL, 32'h1);
    repeat (1200) @(posedge hclk);
    #1 chk({stop_active, cpu_release}, 2'b10); // no wake when disabled
    rdc(`PWU_OFF_STATUS, 32'h0); // nothing latched
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    rdc(`PWU_OFF_OPT_ONE, 32'h0); // reset clears enable
    chk({stop_active, keep, wake_irq}, 3'b010); // reset returns to run mode
    finish_test();
  end
endmodule : pwu_top_bench

// >>> rtl/pwu_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the periodic wake unit.
// Assumes: AHB-Lite word registers, 32-bit data.
// Notes: Included by the bench and by the design modules.
`ifndef PWU_DEFINES_SVH
`define PWU_DEFINES_SVH

`define PWU_OFF_OPT_TWO 12'h000
`define PWU_OFF_OPT_ONE 12'h004
`define PWU_OFF_CTRL 12'h008
`define PWU_OFF_STATUS 12'h00c
`define PWU_OFF_MASK 12'h010
`define PWU_OFF_STATE 12'h014

`define PWU_OPT2_OSC_RUN_BIT 1
`define PWU_OPT1_PERIOD_SEL_BIT 4
`define PWU_OPT1_SHORT_STOP_RECOVERY_BIT 3
`define PWU_OPT1_IRQ_EN_BIT 0
`define PWU_CTRL_STOP_BIT 0
`define PWU_ST_WAKE_BIT 0
`define PWU_ST_EXIT_BIT 1

`define PWU_OPT_TWO_RST 8'h00
`define PWU_OPT_ONE_RST 8'h00

`define PWU_SHORT_PERIOD 15'd512
`define PWU_LONG_PERIOD 15'd16384
`define PWU_SHORT_RECOVERY 13'd32
`define PWU_LONG_RECOVERY 13'd4096

`endif

// >>> rtl/pwu_period_counter.sv
// Purpose: Repeating wake period counter, counting ticks of the selected wake clock.
// Assumes: Tick is a one-cycle pulse at each selected wake clock edge.
// Notes: The period limit follows short_sel on every tick, not only at expiry.
`timescale 1ns/1ps
`include "pwu_defines.svh"
module pwu_period_counter import pwu_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic short_sel,
  // Result
  output logic expire
);
  logic [14:0] cnt_q;
  wire [14:0] limit = short_sel ? `PWU_SHORT_PERIOD : `PWU_LONG_PERIOD;
  wire last = (cnt_q >= limit - 15'd1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 15'h0000;
    end else if (!run) begin
      cnt_q <= 15'h0000;
    end else if (tick) begin
      cnt_q <= last ? 15'h0000 : cnt_q + 15'd1;
    end
  end

  assign expire = run && tick && last;

  expire_spacing_a: assert property (@(posedge hclk) disable iff (!hresetn)
    expire && short_sel |=> !expire [*1]) else $error("expire repeated back to back");
  short_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    expire && short_sel |-> cnt_q == 15'd511) else $error("short period length wrong");
  long_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    expire && !short_sel |-> cnt_q == 15'd16383) else $error("long period length wrong");
endmodule : pwu_period_counter

// >>> rtl/pwu_pkg.sv
// Purpose: Types shared by the periodic wake unit files.
// Assumes: Constants live in pwu_defines.svh.
// Notes: None.
package pwu_pkg;
  typedef enum logic [1:0] {
    PWU_RUN,
    PWU_STOP,
    PWU_RECOVER
  } pwu_state_t;
endpackage : pwu_pkg

// >>> rtl/pwu_top.sv
// Purpose: Periodic wake unit that wakes the processor out of stop mode, on AHB-Lite.
// Assumes: hclk at 200 MHz; doubled and quadrupled bus clocks and the RC clock arrive
// as one-cycle tick inputs synchronous to hclk.
// Notes: Stop entry is a register write or the stop_req pin; exit is after recovery.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "pwu_defines.svh"
module pwu_top import pwu_pkg::*; (
  // AHB-Lite
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock ticks
  input wire logic bus_clock_doubled,
  input wire logic bus_clock_quadrupled,
  input wire logic internal_rc_clock,
  // Power
  input wire logic stop_req,
  output logic clock_keep_in_stop,
  output logic stop_active,
  output logic cpu_release,
  output logic wake_irq
);
  logic [7:0] opt_two_q;
  logic [7:0] opt_one_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [12:0] rec_cnt_q;
  logic keep_q;
  logic stop_q;
  logic release_q;
  logic irq_q;
  logic hreadyout_q;
  logic hresp_q;
  pwu_state_t state_q;
  pwu_state_t state_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  // Bus decode.
  wire addr_ph = hsel && hready && htrans[1];
  wire rd_ph = addr_ph && !hwrite;
  wire wr_ph = addr_ph && hwrite;
  wire w_opt2 = wr_pend_q && hit(wr_addr_q, `PWU_OFF_OPT_TWO);
  wire w_opt1 = wr_pend_q && hit(wr_addr_q, `PWU_OFF_OPT_ONE);
  wire w_ctrl = wr_pend_q && hit(wr_addr_q, `PWU_OFF_CTRL);
  wire w_stat = wr_pend_q && hit(wr_addr_q, `PWU_OFF_STATUS);
  wire w_mask = wr_pend_q && hit(wr_addr_q, `PWU_OFF_MASK);

  wire osc_run_in_stop = opt_two_q[`PWU_OPT2_OSC_RUN_BIT];
  wire wake_period_select = opt_one_q[`PWU_OPT1_PERIOD_SEL_BIT];
  wire short_stop_recovery = opt_one_q[`PWU_OPT1_SHORT_STOP_RECOVERY_BIT];
  wire wake_irq_enable = opt_one_q[`PWU_OPT1_IRQ_EN_BIT];

  wire wake_tick = osc_run_in_stop ? bus_clock_doubled : internal_rc_clock;
  wire in_stop = (state_q == PWU_STOP);
  wire expire;

  pwu_period_counter u_period (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(in_stop),
    .tick(wake_tick),
    .short_sel(wake_period_select),
    .expire(expire)
  );

  wire wake_hit = expire && wake_irq_enable;
  wire [12:0] rec_limit = short_stop_recovery ? `PWU_SHORT_RECOVERY : `PWU_LONG_RECOVERY;
  wire rec_done = bus_clock_quadrupled && (rec_cnt_q >= rec_limit - 13'd1);
  wire stop_go = stop_req || (w_ctrl && hwdata[`PWU_CTRL_STOP_BIT]);
  wire [1:0] ev = {rec_done && state_q == PWU_RECOVER, wake_hit};
  wire [1:0] clr = w_stat ? hwdata[1:0] : 2'b00;
  wire [1:0] status_d = ev | (status_q & ~clr);

  wire [31:0] rd_mux =
    hit(haddr, `PWU_OFF_OPT_TWO) ? {24'h000000, opt_two_q} :
    hit(haddr, `PWU_OFF_OPT_ONE) ? {24'h000000, opt_one_q} :
    hit(haddr, `PWU_OFF_CTRL) ? {31'h00000000, stop_q} :
    hit(haddr, `PWU_OFF_STATUS) ? {30'h00000000, status_q} :
    hit(haddr, `PWU_OFF_MASK) ? {30'h00000000, mask_q} :
    hit(haddr, `PWU_OFF_STATE) ? {30'h00000000, state_q} : 32'h00000000;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PWU_RUN: begin
        if (stop_go) begin
          state_d = PWU_STOP;
        end
      end
      PWU_STOP: begin
        if (wake_hit) begin
          state_d = PWU_RECOVER;
        end
      end
      PWU_RECOVER: begin
        if (rec_done) begin
          state_d = PWU_RUN;
        end
      end
      default: state_d = PWU_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_ph;
      wr_addr_q <= wr_ph ? haddr : wr_addr_q;
      hrdata_q <= rd_ph ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_two_q <= `PWU_OPT_TWO_RST;
      opt_one_q <= `PWU_OPT_ONE_RST;
      mask_q <= 2'b00;
      status_q <= 2'b00;
    end else begin
      opt_two_q <= w_opt2 ? hwdata[7:0] : opt_two_q;
      opt_one_q <= w_opt1 ? hwdata[7:0] : opt_one_q;
      mask_q <= w_mask ? hwdata[1:0] : mask_q;
      status_q <= status_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_cnt_q <= 13'h0000;
    end else if (state_q != PWU_RECOVER) begin
      rec_cnt_q <= 13'h0000;
    end else if (bus_clock_quadrupled) begin
      rec_cnt_q <= rec_cnt_q + 13'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= PWU_RUN;
      keep_q <= 1'b1;
      stop_q <= 1'b0;
      release_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      keep_q <= (state_d != PWU_STOP) || osc_run_in_stop;
      stop_q <= (state_d == PWU_STOP);
      release_q <= (state_q == PWU_RECOVER) && rec_done;
      irq_q <= |(status_d & mask_q);
    end
  end

  assign hrdata = hrdata_q;
  // The slave never stalls and never errors, but both still leave from flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign clock_keep_in_stop = keep_q;
  assign stop_active = stop_q;
  assign cpu_release = release_q;
  assign wake_irq = irq_q;

  irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    expire && !wake_irq_enable |=> !status_q[`PWU_ST_WAKE_BIT] || $past(status_q[0]))
    else $error("wake latched while disabled");
  clock_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_q && !$past(osc_run_in_stop) |-> !clock_keep_in_stop)
    else $error("clock kept in stop while disabled");
  clock_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_run_in_stop |-> wake_tick == bus_clock_doubled)
    else $error("wrong wake clock");
  wake_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    in_stop && wake_hit |=> state_q == PWU_RECOVER)
    else $error("no exit after wake request");
  short_rec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    release_q && $past(short_stop_recovery) |-> $past(rec_cnt_q) == 13'd31)
    else $error("short recovery length wrong");
  long_rec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    release_q && !$past(short_stop_recovery) |-> $past(rec_cnt_q) == 13'd4095)
    else $error("long recovery length wrong");
  stay_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    in_stop && !wake_hit |=> in_stop)
    else $error("left stop without request");
  irq_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_irq |-> $past(|(status_d & mask_q)))
    else $error("interrupt without unmasked status");
  rc_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !osc_run_in_stop |-> wake_tick == internal_rc_clock)
    else $error("rc clock not selected");
  dbl_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    in_stop && osc_run_in_stop |-> wake_tick == bus_clock_doubled)
    else $error("doubled clock not driving generator in stop");
  keep_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_q && $past(osc_run_in_stop) |-> clock_keep_in_stop)
    else $error("clock stopped although kept");
  wake_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_hit |=> status_q[`PWU_ST_WAKE_BIT])
    else $error("enabled wake request not latched");
  exit_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    release_q |-> status_q[`PWU_ST_EXIT_BIT])
    else $error("exit not latched at release");
  release_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    release_q |-> state_q == PWU_RUN)
    else $error("release without return to run");
  release_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    release_q |=> !release_q)
    else $error("release longer than one cycle");
  rec_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q != PWU_RECOVER |=> rec_cnt_q == 13'h0000)
    else $error("recovery count not cleared outside recovery");
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not okay");
  long_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    release_q && !$past(short_stop_recovery));
  stop_cov: cover property (@(posedge hclk) disable iff (!hresetn) state_q == PWU_STOP);
  wake_cov: cover property (@(posedge hclk) disable iff (!hresetn) wake_hit);
  release_cov: cover property (@(posedge hclk) disable iff (!hresetn) release_q);
endmodule : pwu_top
